// file: tccs_channel.sv
// Compare, capture and status registers with waveform pin actions of one timer channel
`timescale 1ns/10ps
`default_nettype none
`include "tccs_regs.svh"

// Notes on behaviour
// - Waveform mode: software trigger applies sw_trig_action_a to timer_io_a.
// - Waveform mode: compare_reg_b match applies cmp_b_action_b to timer_io_b.
// - Waveform mode: period_compare_reg match applies cmp_c_action_b to timer_io_b.
// - Waveform mode: external event applies ext_event_action_b to timer_io_b.
// - Waveform mode: software trigger applies sw_trig_action_b to timer_io_b.
// - Read-only count register shows live 16-bit count, upper bits zero.
// - compare_reg_a read-only in capture mode, writable in waveform mode.
// - compare_reg_b read-only in capture mode, writable in waveform, shows captures.
// - period_compare_reg readable and writable in both modes.
// - overflow_flag set on counter overflow, cleared by status read.
// - Capture only: load_overrun_flag on second load before register read.
// - Waveform only: cmp_a_flag set on compare_reg_a match, cleared by read.
// - Waveform only: cmp_b_flag set on compare_reg_b match, cleared by read.
// - cmp_c_flag set on period match in either mode, cleared by read.
// - Capture only: load_a_flag set when compare_reg_a loads, cleared by read.
// - Capture only: load_b_flag set when compare_reg_b loads, cleared by read.
// - ext_trigger_flag set on external trigger, cleared by status read.
// - Status bit 16 shows live counter clock enable, not cleared by read.
// - Bits 17, 18 mirror pin level in capture, driven level in waveform.
// - pattern_mode_sel 0 selects capture, 1 selects waveform mode.

module tccs_channel (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // APB slave
  input wire tccs_pkg::tccs_apb_req_t APB_REQ,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // Channel side
  input wire logic PATTERN_MODE_SEL,
  input wire logic [15:0] COUNT_VALUE,
  input wire logic CLOCK_RUNNING,
  input wire tccs_pkg::tccs_evt_t EVENTS,
  input wire tccs_pkg::tccs_act_t ACTIONS,
  // Compare match strobes to the channel
  output logic CMP_A_MATCH,
  output logic CMP_B_MATCH,
  output logic CMP_C_MATCH,
  // Pin timer_io_a
  input wire logic TIMER_IO_A_IN,
  output logic TIMER_IO_A_OUT,
  output logic TIMER_IO_A_OE,
  // Pin timer_io_b
  input wire logic TIMER_IO_B_IN,
  output logic TIMER_IO_B_OUT,
  output logic TIMER_IO_B_OE
);

  // ==========================================
  // Functions
  function automatic logic apply_action(input logic cur, input logic [1:0] act);
    logic res;
    res = cur;
    case (act)
      `TCCS_ACT_SET: res = 1'b1;
      `TCCS_ACT_CLR: res = 1'b0;
      `TCCS_ACT_TGL: res = ~cur;
      default: res = cur;
    endcase
    return res;
  endfunction : apply_action

  function automatic logic is_match(input logic [15:0] cnt, input logic [15:0] prev,
                                    input logic [15:0] ref_val);
    return (cnt == ref_val) && (cnt != prev);
  endfunction : is_match

  // ==========================================
  // Declarations
  logic wave;
  logic setup_ph;
  logic xfer_done;
  logic rd_done;
  logic wr_done;
  logic addr_ok;
  logic [15:0] cmp_a_r;
  logic [15:0] cmp_b_r;
  logic [15:0] cmp_c_r;
  logic [15:0] cnt_prev_r;
  logic [15:0] cmp_a_nxt;
  logic [15:0] cmp_b_nxt;
  logic unread_a_r;
  logic unread_b_r;
  tccs_pkg::tccs_flags_t flags_r;
  tccs_pkg::tccs_flags_t flags_set;
  tccs_pkg::tccs_flags_t flags_clr;
  logic [7:0] rd_sticky_r;
  logic m_a;
  logic m_b;
  logic m_c;
  logic pin_a_r;
  logic pin_b_r;
  logic pin_b_nxt;
  logic pin_a_mirror;
  logic pin_b_mirror;
  logic [31:0] status_word;
  logic [31:0] rdata_nxt;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic cmp_a_match_r;
  logic cmp_b_match_r;
  logic cmp_c_match_r;
  logic oe_r;

  // ==========================================
  // Mode and bus phases
  assign wave = (PATTERN_MODE_SEL == `TCCS_MODE_WAVE);
  assign setup_ph = APB_REQ.psel & ~APB_REQ.penable;
  assign xfer_done = APB_REQ.psel & APB_REQ.penable & pready_r;
  assign rd_done = xfer_done & ~APB_REQ.pwrite;
  assign wr_done = xfer_done & APB_REQ.pwrite & ~pslverr_r;

  always_comb begin
    case (APB_REQ.paddr)
      `TCCS_OFF_COUNT, `TCCS_OFF_CMP_A, `TCCS_OFF_CMP_B,
      `TCCS_OFF_CMP_C, `TCCS_OFF_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // ==========================================
  // Compare matches
  assign m_a = is_match(COUNT_VALUE, cnt_prev_r, cmp_a_r);
  assign m_b = is_match(COUNT_VALUE, cnt_prev_r, cmp_b_r);
  assign m_c = is_match(COUNT_VALUE, cnt_prev_r, cmp_c_r);

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_prev_r <= 16'h0000;
      cmp_a_match_r <= 1'b0;
      cmp_b_match_r <= 1'b0;
      cmp_c_match_r <= 1'b0;
    end else begin
      cnt_prev_r <= COUNT_VALUE;
      cmp_a_match_r <= m_a & wave;
      cmp_b_match_r <= m_b & wave;
      cmp_c_match_r <= m_c;
    end
  end

  // ==========================================
  // Compare registers
  always_comb begin
    cmp_a_nxt = cmp_a_r;
    cmp_b_nxt = cmp_b_r;
    if (!wave && EVENTS.load_a) begin
      cmp_a_nxt = COUNT_VALUE;
    end else if (wave && wr_done && APB_REQ.paddr == `TCCS_OFF_CMP_A) begin
      cmp_a_nxt = APB_REQ.pwdata[15:0];
    end
    if (!wave && EVENTS.load_b) begin
      cmp_b_nxt = COUNT_VALUE;
    end else if (wave && wr_done && APB_REQ.paddr == `TCCS_OFF_CMP_B) begin
      cmp_b_nxt = APB_REQ.pwdata[15:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmp_a_r <= `TCCS_CMP_RST;
      cmp_b_r <= `TCCS_CMP_RST;
      cmp_c_r <= `TCCS_CMP_RST;
    end else begin
      cmp_a_r <= cmp_a_nxt;
      cmp_b_r <= cmp_b_nxt;
      if (wr_done && APB_REQ.paddr == `TCCS_OFF_CMP_C) begin
        cmp_c_r <= APB_REQ.pwdata[15:0];
      end
    end
  end

  // ==========================================
  // Unread tracking for load overrun
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      unread_a_r <= 1'b0;
      unread_b_r <= 1'b0;
    end else begin
      if (!wave && EVENTS.load_a) begin
        unread_a_r <= 1'b1;
      end else if (rd_done && APB_REQ.paddr == `TCCS_OFF_CMP_A) begin
        unread_a_r <= 1'b0;
      end
      if (!wave && EVENTS.load_b) begin
        unread_b_r <= 1'b1;
      end else if (rd_done && APB_REQ.paddr == `TCCS_OFF_CMP_B) begin
        unread_b_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // Sticky flags
  always_comb begin
    flags_set = '0;
    flags_set.overflow_flag = EVENTS.overflow;
    flags_set.load_overrun_flag = ~wave & ((EVENTS.load_a & unread_a_r) |
                                          (EVENTS.load_b & unread_b_r));
    flags_set.cmp_a_flag = wave & m_a;
    flags_set.cmp_b_flag = wave & m_b;
    flags_set.cmp_c_flag = m_c;
    flags_set.load_a_flag = ~wave & EVENTS.load_a;
    flags_set.load_b_flag = ~wave & EVENTS.load_b;
    flags_set.ext_trigger_flag = EVENTS.ext_trigger;
    flags_clr = '0;
    if (rd_done && APB_REQ.paddr == `TCCS_OFF_STATUS) begin
      flags_clr = tccs_pkg::tccs_flags_t'(rd_sticky_r);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_r <= '0;
    end else begin
      flags_r <= (flags_r & ~flags_clr) | flags_set;
    end
  end

  // ==========================================
  // Waveform pin actions
  always_comb begin
    pin_b_nxt = pin_b_r;
    if (wave) begin
      if (m_b) begin
        pin_b_nxt = apply_action(pin_b_nxt, ACTIONS.cmp_b_action_b);
      end
      if (m_c) begin
        pin_b_nxt = apply_action(pin_b_nxt, ACTIONS.cmp_c_action_b);
      end
      if (EVENTS.ext_event) begin
        pin_b_nxt = apply_action(pin_b_nxt, ACTIONS.ext_event_action_b);
      end
      if (EVENTS.sw_trigger) begin
        pin_b_nxt = apply_action(pin_b_nxt, ACTIONS.sw_trig_action_b);
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_a_r <= 1'b0;
      pin_b_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      oe_r <= wave;
      pin_b_r <= pin_b_nxt;
      if (wave && EVENTS.sw_trigger) begin
        pin_a_r <= apply_action(pin_a_r, ACTIONS.sw_trig_action_a);
      end
    end
  end

  // ==========================================
  // Status word and read mux
  assign pin_a_mirror = wave ? pin_a_r : TIMER_IO_A_IN;
  assign pin_b_mirror = wave ? pin_b_r : TIMER_IO_B_IN;

  always_comb begin
    status_word = 32'h00000000;
    status_word[7:0] = flags_r;
    status_word[`TCCS_SR_CLK] = CLOCK_RUNNING;
    status_word[`TCCS_SR_MIRA] = pin_a_mirror;
    status_word[`TCCS_SR_MIRB] = pin_b_mirror;
    case (APB_REQ.paddr)
      `TCCS_OFF_COUNT: rdata_nxt = {16'h0000, COUNT_VALUE};
      `TCCS_OFF_CMP_A: rdata_nxt = {16'h0000, cmp_a_r};
      `TCCS_OFF_CMP_B: rdata_nxt = {16'h0000, cmp_b_r};
      `TCCS_OFF_CMP_C: rdata_nxt = {16'h0000, cmp_c_r};
      `TCCS_OFF_STATUS: rdata_nxt = status_word;
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // ==========================================
  // APB response, one wait-free access cycle
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
      rd_sticky_r <= 8'h00;
    end else begin
      pready_r <= setup_ph;
      pslverr_r <= setup_ph & ~addr_ok;
      if (setup_ph && !APB_REQ.pwrite) begin
        prdata_r <= rdata_nxt;
        rd_sticky_r <= rdata_nxt[7:0] & `TCCS_STICKY_MASK;
      end else if (xfer_done) begin
        prdata_r <= 32'h00000000;
        rd_sticky_r <= 8'h00;
      end
    end
  end

  // ==========================================
  // Outputs
  assign PREADY = pready_r;
  assign PRDATA = prdata_r;
  assign PSLVERR = pslverr_r;
  assign CMP_A_MATCH = cmp_a_match_r;
  assign CMP_B_MATCH = cmp_b_match_r;
  assign CMP_C_MATCH = cmp_c_match_r;
  assign TIMER_IO_A_OUT = pin_a_r;
  assign TIMER_IO_B_OUT = pin_b_r;
  assign TIMER_IO_A_OE = oe_r;
  assign TIMER_IO_B_OE = oe_r;

endmodule : tccs_channel

`default_nettype wire

// file: tccs_regs.svh
// Register offsets, field positions and encodings of the timer channel compare/status block
`ifndef TCCS_REGS_SVH
`define TCCS_REGS_SVH

// ==========================================
// Register byte offsets
`define TCCS_OFF_COUNT 8'h00
`define TCCS_OFF_CMP_A 8'h04
`define TCCS_OFF_CMP_B 8'h08
`define TCCS_OFF_CMP_C 8'h0C
`define TCCS_OFF_STATUS 8'h10

// ==========================================
// Widths and reset values
`define TCCS_CNT_W 16
`define TCCS_CMP_RST 16'h0000

// ==========================================
// Status bit positions
`define TCCS_SR_OVF 0
`define TCCS_SR_LOVR 1
`define TCCS_SR_CPA 2
`define TCCS_SR_CPB 3
`define TCCS_SR_CPC 4
`define TCCS_SR_LDA 5
`define TCCS_SR_LDB 6
`define TCCS_SR_ETRG 7
`define TCCS_SR_CLK 16
`define TCCS_SR_MIRA 17
`define TCCS_SR_MIRB 18
`define TCCS_STICKY_MASK 8'hFF

// ==========================================
// Pin action encoding
`define TCCS_ACT_NONE 2'h0
`define TCCS_ACT_SET 2'h1
`define TCCS_ACT_CLR 2'h2
`define TCCS_ACT_TGL 2'h3

// ==========================================
// Mode select values
`define TCCS_MODE_CAPTURE 1'h0
`define TCCS_MODE_WAVE 1'h1

`endif

// file: tccs_pkg.sv
// Types shared by the timer channel compare/status block
`default_nettype none

package tccs_pkg;

  // ==========================================
  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tccs_apb_req_t;

  // ==========================================
  // One-cycle event strobes from the channel
  typedef struct packed {
    logic overflow;
    logic load_a;
    logic load_b;
    logic ext_trigger;
    logic ext_event;
    logic sw_trigger;
  } tccs_evt_t;

  // ==========================================
  // Waveform pin actions from the mode register
  typedef struct packed {
    logic [1:0] sw_trig_action_a;
    logic [1:0] sw_trig_action_b;
    logic [1:0] cmp_b_action_b;
    logic [1:0] cmp_c_action_b;
    logic [1:0] ext_event_action_b;
  } tccs_act_t;

  // ==========================================
  // Sticky status flags
  typedef struct packed {
    logic ext_trigger_flag;
    logic load_b_flag;
    logic load_a_flag;
    logic cmp_c_flag;
    logic cmp_b_flag;
    logic cmp_a_flag;
    logic load_overrun_flag;
    logic overflow_flag;
  } tccs_flags_t;

endpackage : tccs_pkg

`default_nettype wire

// file: tccs_pin_model.sv
// Outside world at one channel pin
`timescale 1ns/10ps
`default_nettype none

module tccs_pin_model (
  // Design side
  input wire logic drv_out,
  input wire logic drv_oe,
  // Outside level
  input wire logic ext_level,
  output logic pin_level
);
  // ==========================================
  // Wire level: the block wins while it drives
  assign pin_level = drv_oe ? drv_out : ext_level;
endmodule : tccs_pin_model

`default_nettype wire

// file: tccs_channel_sva.sv
// Assertion checker for the timer channel compare/status block
`timescale 1ns/10ps
`default_nettype none
`include "tccs_regs.svh"

module tccs_channel_sva (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // APB slave
  input wire tccs_pkg::tccs_apb_req_t APB_REQ,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // Channel side
  input wire logic PATTERN_MODE_SEL,
  input wire logic [15:0] COUNT_VALUE,
  input wire logic CLOCK_RUNNING,
  input wire tccs_pkg::tccs_evt_t EVENTS,
  input wire tccs_pkg::tccs_act_t ACTIONS,
  input wire logic CMP_A_MATCH,
  input wire logic CMP_B_MATCH,
  input wire logic CMP_C_MATCH,
  // Pins
  input wire logic TIMER_IO_A_OUT,
  input wire logic TIMER_IO_A_OE,
  input wire logic TIMER_IO_B_OUT,
  input wire logic TIMER_IO_B_OE
);
  // ==========================================
  // Helpers
  logic setup;
  logic rd;
  logic wav;
  assign setup = APB_REQ.psel && !APB_REQ.penable;
  assign rd = setup && !APB_REQ.pwrite;
  assign wav = PATTERN_MODE_SEL;
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  // ==========================================
  // Properties
  a_count_live:
  assert property (rd && APB_REQ.paddr == `TCCS_OFF_COUNT |=> PREADY && PRDATA == {16'h0000, $past(COUNT_VALUE)})
    else $error("count read wrong");
  a_status_live:
  assert property (rd && APB_REQ.paddr == `TCCS_OFF_STATUS |=> PRDATA[16] == $past(CLOCK_RUNNING)
    && PRDATA[31:19] == 13'h0000 && PRDATA[15:8] == 8'h00) else $error("status read wrong");
  a_unmapped_err:
  assert property (setup && APB_REQ.paddr > `TCCS_OFF_STATUS |=> PSLVERR && PRDATA == 32'h00000000)
    else $error("unmapped access not refused");
  a_drive_wave:
  assert property (wav |=> TIMER_IO_A_OE && TIMER_IO_B_OE) else $error("pins not driven");
  a_cmp_a_capture:
  assert property (!wav |=> !CMP_A_MATCH) else $error("compare A match in capture");
  a_cmp_b_capture:
  assert property (!wav |=> !CMP_B_MATCH) else $error("compare B match in capture");
  a_cmp_c_single:
  assert property (CMP_C_MATCH |=> !CMP_C_MATCH) else $error("period match longer than one cycle");
  a_swtrg_toggle:
  assert property (wav && EVENTS.sw_trigger && ACTIONS.sw_trig_action_a == `TCCS_ACT_TGL
    |=> TIMER_IO_A_OUT != $past(TIMER_IO_A_OUT)) else $error("pin A not toggled");
  a_pin_a_quiet:
  assert property (wav && !EVENTS.sw_trigger |=> $stable(TIMER_IO_A_OUT)) else $error("pin A moved");
  a_swtrg_clear_b:
  assert property (wav && EVENTS.sw_trigger && ACTIONS.sw_trig_action_b == `TCCS_ACT_CLR |=> !TIMER_IO_B_OUT)
    else $error("pin B not cleared");
  a_ext_set_b:
  assert property (wav && EVENTS.ext_event && !EVENTS.sw_trigger && ACTIONS.ext_event_action_b == `TCCS_ACT_SET
    |=> TIMER_IO_B_OUT) else $error("pin B not set");
endmodule : tccs_channel_sva

bind tccs_channel tccs_channel_sva u_tccs_channel_sva (.CORE_CLK, .RST_N, .APB_REQ, .PREADY, .PRDATA,
  .PSLVERR, .PATTERN_MODE_SEL, .COUNT_VALUE, .CLOCK_RUNNING, .EVENTS, .ACTIONS, .CMP_A_MATCH,
  .CMP_B_MATCH, .CMP_C_MATCH,
  .TIMER_IO_A_OUT, .TIMER_IO_A_OE, .TIMER_IO_B_OUT, .TIMER_IO_B_OE);

`default_nettype wire

// file: tccs_channel_tb.sv
// Self-checking bench for the timer channel compare/status block
`timescale 1ns/10ps
`default_nettype none

module tccs_channel_tb;
  // ==========================================
  // Signals
  typedef struct packed {
    logic mode;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic err;
  } tccs_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b0;
  logic clkrun = 1'b1;
  logic ext_a = 1'b1;
  logic ext_b = 1'b0;
  logic [15:0] cnt = 16'hA5A5;
  tccs_pkg::tccs_apb_req_t req = '0;
  tccs_pkg::tccs_evt_t ev = '0;
  tccs_pkg::tccs_act_t act = '0;
  logic pready, pslverr, a_out, a_oe, b_out, b_oe, a_in, b_in, e, pa, pb;
  logic [31:0] prdata, q;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  tccs_row_t rows [9];
  logic [1:0] codes [5];

  tccs_channel u_tccs_channel (.CORE_CLK(clk), .RST_N(rst_n), .APB_REQ(req), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .PATTERN_MODE_SEL(mode), .COUNT_VALUE(cnt),
    .CLOCK_RUNNING(clkrun), .EVENTS(ev), .ACTIONS(act), .CMP_A_MATCH(), .CMP_B_MATCH(),
    .CMP_C_MATCH(), .TIMER_IO_A_IN(a_in), .TIMER_IO_A_OUT(a_out), .TIMER_IO_A_OE(a_oe),
    .TIMER_IO_B_IN(b_in), .TIMER_IO_B_OUT(b_out), .TIMER_IO_B_OE(b_oe));
  tccs_pin_model u_pin_a (.drv_out(a_out), .drv_oe(a_oe), .ext_level(ext_a), .pin_level(a_in));
  tccs_pin_model u_pin_b (.drv_out(b_out), .drv_oe(b_oe), .ext_level(ext_b), .pin_level(b_in));

  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail_count++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    q = prdata;
    e = pslverr;
    req <= '0;
    @(posedge clk);
  endtask : apb

  task automatic pulse(input tccs_pkg::tccs_evt_t p);
    ev <= p;
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
  endtask : pulse

  function automatic logic app(input logic [1:0] c, input logic v);
    return (c == 2'h1) ? 1'b1 : (c == 2'h2) ? 1'b0 : (c == 2'h3) ? !v : v;
  endfunction : app

  task automatic conclude();
    $display("mismatches %0d of %0d checks", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // ==========================================
  // Clock and watchdog
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      conclude();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    rows = '{'{1'b0, 8'h04, 32'h0000FFFF, 32'h0, 1'b0}, '{1'b1, 8'h04, 32'hABCD1234, 32'h1234, 1'b0},
      '{1'b0, 8'h04, 32'h00005555, 32'h1234, 1'b0}, '{1'b1, 8'h08, 32'hFFFF0F0F, 32'h0F0F, 1'b0},
      '{1'b0, 8'h08, 32'h00000001, 32'h0F0F, 1'b0}, '{1'b0, 8'h0C, 32'h12345678, 32'h5678, 1'b0},
      '{1'b1, 8'h0C, 32'h0000BEEF, 32'hBEEF, 1'b0}, '{1'b0, 8'h00, 32'h0000FFFF, 32'hA5A5, 1'b0},
      '{1'b0, 8'h14, 32'hFFFFFFFF, 32'h0, 1'b1}};
    codes = '{2'h1, 2'h3, 2'h2, 2'h3, 2'h0};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      mode <= rows[i].mode;
      apb(1'b1, rows[i].addr, rows[i].wdata);
      apb(1'b0, rows[i].addr, 32'h0);
      chk(q, rows[i].exp);
      chk({31'h0, e}, {31'h0, rows[i].err});
    end
    // Capture flags: overflow, both loads, external trigger
    mode <= 1'b0;
    cnt <= 16'h0042;
    pulse(6'h3C);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h000300E1);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h00030000);
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h00000042);
    cnt <= 16'h0043;
    pulse(6'h10);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h00030022);
    fork
      apb(1'b0, 8'h10, 32'h0);
      begin
        @(posedge clk);
        ev <= 6'h04;
        @(posedge clk);
        ev <= '0;
      end
    join
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h00030080);
    // Waveform pin actions, every code
    mode <= 1'b1;
    pa = 1'b0;
    pb = 1'b0;
    foreach (codes[i]) begin
      act <= {codes[i], codes[i], 4'h0, codes[4 - i]};
      pulse(6'h01);
      pa = app(codes[i], pa);
      pb = app(codes[i], pb);
      chk({30'h0, b_out, a_out}, {30'h0, pb, pa});
      pulse(6'h12);
      pb = app(codes[4 - i], pb);
      chk({31'h0, b_out}, {31'h0, pb});
    end
    apb(1'b0, 8'h10, 32'h0);
    chk(q, {13'h0, pb, pa, 1'b1, 16'h0});
    // Compare matches drive pin B and flags
    apb(1'b1, 8'h04, 32'h30);
    apb(1'b1, 8'h08, 32'h10);
    apb(1'b1, 8'h0C, 32'h20);
    act <= 10'h034;
    cnt <= 16'h0010;
    repeat (2) @(posedge clk);
    chk({31'h0, b_out}, 32'h0);
    cnt <= 16'h0020;
    repeat (2) @(posedge clk);
    chk({31'h0, b_out}, 32'h1);
    cnt <= 16'h0030;
    repeat (2) @(posedge clk);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, {13'h0, 1'b1, pa, 1'b1, 16'h001C});
    // Reset in mid-run clears pins, compare registers and flags
    rst_n <= 1'b0;
    @(posedge clk);
    chk({28'h0, a_out, b_out, a_oe, b_oe}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h00000000);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h00010000);
    conclude();
  end
endmodule : tccs_channel_tb

`default_nettype wire
